// ### rtl/cpu_timer_triplet.sv
// Functional notes
// - Three identical 32-bit down-counting timers.
// - Each timer has a 16-bit prescaler.
// - Counter decrements at core clock over prescale.
// - Reaching zero raises the timer interrupt.
// - Zero reloads the period automatically, counting continues.
// - Timer 2 drives core line fourteen.
// - Timer 1 connectable to core line thirteen.
// - Timer 0 goes to the interrupt expander.
// - Registers sit on the core memory bus.
// - Frame takes 16-bit and 32-bit accesses.
module cpu_timer_triplet (
  input  wire logic                       CORE_CLK,
  input  wire logic                       ARST_N,
  input  wire cpu_timer_pkg::frame_req_t  FRAME,
  output logic [31:0]                     FRAME_RDATA,
  output cpu_timer_pkg::count_bank_t      TIMER_COUNT,
  input  wire logic                       ACK_EXPANDER,
  input  wire logic                       ACK_LINE_THIRTEEN,
  input  wire logic                       ACK_LINE_FOURTEEN,
  output logic                            INTERRUPT_EXPANDER,
  output logic                            CORE_IRQ_LINE_THIRTEEN,
  output logic                            CORE_IRQ_LINE_FOURTEEN
);
  import cpu_timer_pkg::*;

  typedef struct packed {
    logic [NUM_TIMERS-1:0][COUNT_W-1:0]    period;
    logic [NUM_TIMERS-1:0][PRESCALE_W-1:0] prescale;
    logic [NUM_TIMERS-1:0]                 stop;
    logic                                  route13;
    logic [31:0]                           rdata;
  } frame_state_t;

  frame_state_t          st;
  frame_state_t          next_st;
  count_bank_t           count;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] wrap;
  logic [NUM_TIMERS-1:0] flag;
  logic [NUM_TIMERS-1:0] ack;
  logic [NUM_TIMERS-1:0] reload_pulse;
  logic [NUM_TIMERS-1:0] clear_pulse;
  logic [1:0][2:0]       word_idx;
  logic [1:0][15:0]      half_wdata;
  logic [1:0][15:0]      half_rdata;
  logic [1:0]            half_act;
  logic [1:0]            sel;
  logic                  hit;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of core memory bus accesses. A wide access covers the even word
  // and the one above it; reading the count in two narrow halves is not
  // atomic, so software should use a wide read for a coherent value.
  always_comb begin
    next_st      = st;
    reload_pulse = '0;
    clear_pulse  = '0;
    half_rdata   = '0;
    sel          = FRAME.addr[4:3];
    hit          = (FRAME.addr[5] == 1'b0) && (sel < NUM_TIMERS);
    for (int h = 0; h < 2; h++) begin
      word_idx[h]   = FRAME.wide ? {FRAME.addr[2:1], h[0]} : FRAME.addr[2:0];
      half_act[h]   = FRAME.wide || (h == 0);
      half_wdata[h] = (h == 1) ? FRAME.wdata[31:16] : FRAME.wdata[15:0];
      if (hit && half_act[h]) begin
        case (word_idx[h])
          OFS_COUNT_LO:  half_rdata[h] = count[sel][15:0];
          OFS_COUNT_HI:  half_rdata[h] = count[sel][31:16];
          OFS_PERIOD_LO: half_rdata[h] = st.period[sel][15:0];
          OFS_PERIOD_HI: half_rdata[h] = st.period[sel][31:16];
          OFS_CTRL: begin
            half_rdata[h][CTRL_STOP_BIT] = st.stop[sel];
            half_rdata[h][CTRL_FLAG_BIT] = flag[sel];
            if (sel == LINE13_TIMER) begin
              half_rdata[h][CTRL_ROUTE13_BIT] = st.route13;
            end
          end
          OFS_PRESCALE:  half_rdata[h] = st.prescale[sel];
          default:       half_rdata[h] = '0;
        endcase
      end
      if (FRAME.wr && hit && half_act[h]) begin
        case (word_idx[h])
          OFS_PERIOD_LO: next_st.period[sel][15:0]  = half_wdata[h];
          OFS_PERIOD_HI: next_st.period[sel][31:16] = half_wdata[h];
          OFS_CTRL: begin
            clear_pulse[sel]  = half_wdata[h][CTRL_CLEAR_BIT];
            reload_pulse[sel] = half_wdata[h][CTRL_RELOAD_BIT];
            next_st.stop[sel] = half_wdata[h][CTRL_STOP_BIT];
            if (sel == LINE13_TIMER) begin
              next_st.route13 = half_wdata[h][CTRL_ROUTE13_BIT];
            end
          end
          OFS_PRESCALE:  next_st.prescale[sel] = half_wdata[h];
          default: ;
        endcase
      end
    end
    if (FRAME.rd) begin
      next_st.rdata = {half_rdata[1], half_rdata[0]};
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st.period   <= {NUM_TIMERS{PERIOD_RST}};
      st.prescale <= {NUM_TIMERS{PRESCALE_RST}};
      st.stop     <= '0;
      st.route13  <= 1'b0;
      st.rdata    <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ack[EXPANDER_TIMER] = ACK_EXPANDER;
  assign ack[LINE13_TIMER]   = ACK_LINE_THIRTEEN;
  assign ack[LINE14_TIMER]   = ACK_LINE_FOURTEEN;

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    cpu_timer_unit #(
      .COUNT_W    (COUNT_W),
      .PRESCALE_W (PRESCALE_W)
    ) u_unit (
      .clk      (CORE_CLK),
      .arst_n   (ARST_N),
      .run      (!st.stop[i]),
      .reload   (reload_pulse[i]),
      .clear    (clear_pulse[i] || ack[i]),
      .period   (st.period[i]),
      .prescale (st.prescale[i]),
      .count    (count[i]),
      .tick     (tick[i]),
      .wrap     (wrap[i]),
      .flag     (flag[i])
    );
  end

  assign TIMER_COUNT            = count;
  assign FRAME_RDATA            = st.rdata;
  assign INTERRUPT_EXPANDER     = flag[EXPANDER_TIMER];
  // Line thirteen is shared with other sources, so the timer only drives it
  // when software has connected it.
  assign CORE_IRQ_LINE_THIRTEEN = flag[LINE13_TIMER] && st.route13;
  assign CORE_IRQ_LINE_FOURTEEN = flag[LINE14_TIMER];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_check
    wrap_sets_flag_a: assert property (wrap[i] |=> flag[i])
      else $error("wrap did not raise the flag");
    wrap_reload_a: assert property (wrap[i] && !reload_pulse[i] |=>
      count[i] == $past(st.period[i]))
      else $error("count not reloaded from period");
    tick_step_a: assert property (tick[i] && !wrap[i] && !reload_pulse[i] |=>
      count[i] == $past(count[i]) - 32'h1)
      else $error("count did not step down by one");
    idle_hold_a: assert property (!tick[i] && !reload_pulse[i] |=>
      count[i] == $past(count[i]))
      else $error("count moved without a prescaler pulse");
    flag_sticky_a: assert property (flag[i] && !clear_pulse[i] && !ack[i] |=>
      flag[i])
      else $error("flag dropped without a clear");
    // A reload inside the window restarts the divider, so it is kept out of it.
    psc_gap_a: assert property (tick[i] && st.prescale[i] == 16'h3 &&
      !reload_pulse[i] && !st.stop[i] ##1 !st.stop[i] && !reload_pulse[i] ##1
      !st.stop[i] && !reload_pulse[i] |->
      !$past(tick[i]) && !tick[i] ##1 tick[i] || st.stop[i])
      else $error("prescaler period wrong");
    stop_hold_a: assert property (st.stop[i] && !reload_pulse[i] |=>
      count[i] == $past(count[i]))
      else $error("count moved while stopped");
    div_one_a: assert property (tick[i] && st.prescale[i] <= 16'h1 |=>
      tick[i] || st.stop[i])
      else $error("divide by one skipped a pulse");
    reload_load_a: assert property (reload_pulse[i] |=>
      count[i] == $past(st.period[i]))
      else $error("reload did not load the period");
    set_wins_a: assert property (wrap[i] &&
      (clear_pulse[i] || ack[i]) |=> flag[i])
      else $error("clear beat a wrap");
    flag_clear_a: assert property (flag[i] && !wrap[i] &&
      (clear_pulse[i] || ack[i]) |=> !flag[i])
      else $error("flag not cleared");
  end

  line14_a: assert property (wrap[LINE14_TIMER] |=> CORE_IRQ_LINE_FOURTEEN)
    else $error("line fourteen missed its timer");
  line13_gate_a: assert property (!st.route13 |-> !CORE_IRQ_LINE_THIRTEEN)
    else $error("line thirteen driven while disconnected");
  expander_a: assert property (wrap[EXPANDER_TIMER] |=> INTERRUPT_EXPANDER)
    else $error("expander request missed");
  wide_read_a: assert property (FRAME.rd && FRAME.wide && FRAME.addr == 6'h02 |=>
    FRAME_RDATA == $past(st.period[0]))
    else $error("wide period read wrong");
  // Unmapped and narrow reads must never leak stale data into the upper half.
  unmapped_read_a: assert property (FRAME.rd && !hit |=> FRAME_RDATA == 32'h0)
    else $error("unmapped read not zero");
  narrow_read_a: assert property (FRAME.rd && !FRAME.wide |=>
    FRAME_RDATA[31:16] == 16'h0)
    else $error("narrow read upper half not zero");
  wide_count_a: assert property (FRAME.rd && FRAME.wide && FRAME.addr == 6'h00 |=>
    FRAME_RDATA == $past(count[0]))
    else $error("wide count read wrong");
  route13_hold_a: assert property (!FRAME.wr |=> st.route13 == $past(st.route13))
    else $error("route bit changed without a write");

  wrap_c:    cover property (wrap[LINE14_TIMER] ##1 CORE_IRQ_LINE_FOURTEEN);
  ack_c:     cover property (CORE_IRQ_LINE_THIRTEEN ##1 ACK_LINE_THIRTEEN);
  narrow_c:  cover property (FRAME.wr && !FRAME.wide && hit);
  reload_c:  cover property (reload_pulse[EXPANDER_TIMER]);
  stop_c:    cover property (st.stop[EXPANDER_TIMER] ##1 !st.stop[EXPANDER_TIMER]);

endmodule

// ### rtl/cpu_timer_pkg.sv
package cpu_timer_pkg;

  localparam int NUM_TIMERS = 3;
  localparam int COUNT_W    = 32;
  localparam int PRESCALE_W = 16;
  localparam int HALF_W     = 16;

  // Word offsets (16-bit units) inside one timer's eight-word slot.
  localparam logic [2:0] OFS_COUNT_LO  = 3'h0;
  localparam logic [2:0] OFS_COUNT_HI  = 3'h1;
  localparam logic [2:0] OFS_PERIOD_LO = 3'h2;
  localparam logic [2:0] OFS_PERIOD_HI = 3'h3;
  localparam logic [2:0] OFS_CTRL      = 3'h4;
  localparam logic [2:0] OFS_PRESCALE  = 3'h6;

  // Control word bit positions.
  localparam int CTRL_CLEAR_BIT   = 0;
  localparam int CTRL_RELOAD_BIT  = 1;
  localparam int CTRL_STOP_BIT    = 2;
  localparam int CTRL_ROUTE13_BIT = 3;
  localparam int CTRL_FLAG_BIT    = 4;

  // Timer instance numbers with a fixed interrupt destination.
  localparam int EXPANDER_TIMER = 0;
  localparam int LINE13_TIMER   = 1;
  localparam int LINE14_TIMER   = 2;

  localparam logic [COUNT_W-1:0]    PERIOD_RST   = 32'hffff_ffff;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 16'h0001;

  // One access from the core memory bus into the timer slots.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        wide;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } frame_req_t;

  typedef logic [NUM_TIMERS-1:0][COUNT_W-1:0] count_bank_t;

endpackage

// ### rtl/cpu_timer_unit.sv
module cpu_timer_unit #(
  parameter int COUNT_W    = cpu_timer_pkg::COUNT_W,
  parameter int PRESCALE_W = cpu_timer_pkg::PRESCALE_W
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  run,
  input  wire logic                  reload,
  input  wire logic                  clear,
  input  wire logic [COUNT_W-1:0]    period,
  input  wire logic [PRESCALE_W-1:0] prescale,
  output logic      [COUNT_W-1:0]    count,
  output logic                       tick,
  output logic                       wrap,
  output logic                       flag
);
  import cpu_timer_pkg::*;

  typedef struct packed {
    logic [COUNT_W-1:0]    count;
    logic [PRESCALE_W-1:0] psc;
    logic                  flag;
  } unit_state_t;

  unit_state_t st;
  unit_state_t next_st;
  logic [PRESCALE_W-1:0] psc_start;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st   = st;
    // A setting of zero divides by one, so the counter never stalls.
    psc_start = (prescale == '0) ? '0 : prescale - 1'b1;
    tick      = run && (st.psc == '0);
    wrap      = tick && (st.count == '0);
    if (tick) begin
      next_st.psc = psc_start;
    end else if (run) begin
      next_st.psc = st.psc - 1'b1;
    end
    if (wrap) begin
      next_st.count = period;
    end else if (tick) begin
      next_st.count = st.count - 1'b1;
    end
    if (reload) begin
      next_st.count = period;
      next_st.psc   = psc_start;
    end
    // Setting wins over clearing so a wrap in the clear cycle is kept.
    if (clear) begin
      next_st.flag = 1'b0;
    end
    if (wrap) begin
      next_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.count <= {COUNT_W{1'b1}};
      st.psc   <= '0;
      st.flag  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
  assign flag  = st.flag;

endmodule

// ### sim/irq_partner.sv
// Stand-in for the core interrupt controller and the expander. It acknowledges each
// raised line after a programmable wait so that prompt and slow service both occur.
module irq_partner (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire logic [3:0] delay,
  input  wire logic [2:0] irq,
  output logic      [2:0] ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0][3:0] wait_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // The counter restarts after each pulse, so one request never draws two pulses.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= '0;
      ack      <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // A shorter wait set mid-count must not leave a request unserved.
        ack[i]      <= enable && irq[i] && !ack[i] && wait_cnt[i] >= delay;
        wait_cnt[i] <= (irq[i] && !ack[i] && wait_cnt[i] < delay) ? wait_cnt[i] + 4'h1 : 4'h0;
      end
    end
  end
endmodule

// ### sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_timer_pkg::*;
  logic        core_clk;
  logic        arst_n;
  frame_req_t  frame;
  logic [31:0] rdata;
  count_bank_t count;
  logic [2:0]  ack;
  logic [2:0]  irq;
  logic        ack_en;
  logic [3:0]  ack_dly;
  int          fail_count;
  int          tests_run;
  int          cyc;
  int          k;
  int          p;
  int          ps;
  int          t0;
  int          t1;
  logic [31:0] held;
  ////////////////////////////////////////////////////////////////////////////////
  cpu_timer_triplet i_dut (
    .CORE_CLK               (core_clk),
    .ARST_N                 (arst_n),
    .FRAME                  (frame),
    .FRAME_RDATA            (rdata),
    .TIMER_COUNT            (count),
    .ACK_EXPANDER           (ack[0]),
    .ACK_LINE_THIRTEEN      (ack[1]),
    .ACK_LINE_FOURTEEN      (ack[2]),
    .INTERRUPT_EXPANDER     (irq[0]),
    .CORE_IRQ_LINE_THIRTEEN (irq[1]),
    .CORE_IRQ_LINE_FOURTEEN (irq[2])
  );
  irq_partner i_partner (
    .clk    (core_clk),
    .arst_n (arst_n),
    .enable (ack_en),
    .delay  (ack_dly),
    .irq    (irq),
    .ack    (ack)
  );
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] slot(input int t, input logic [2:0] w);
    return {1'b0, t[1:0], w};
  endfunction
  function automatic int gap(input int per, input int pre);
    return (per + 1) * ((pre == 0) ? 1 : pre);
  endfunction
  // An idle cycle follows every access, so no strobe is driven twice in one step.
  task automatic bus(input logic w, input logic wd, input logic [5:0] a, input logic [31:0] d);
    frame.wr = w;
    frame.rd = !w;
    frame.wide = wd;
    frame.addr = a;
    frame.wdata = d;
    @(posedge core_clk);
    #1;
    frame = '0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic rd_chk(input logic wd, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, wd, a, 32'h0);
    check(rdata, exp, "read data");
  endtask
  task automatic wait_rise(input int t, output int stamp);
    logic prev;
    logic seen;
    prev = irq[t];
    seen = 1'b0;
    for (int n = 0; n < 2000 && !seen; n++) begin
      @(posedge core_clk);
      #1;
      seen = irq[t] && !prev;
      prev = irq[t];
    end
    stamp = cyc;
    if (!seen) begin
      fail_count++;
      $display("mismatch at %0t: no interrupt edge on timer %0d", $time, t);
    end
  endtask
  task automatic setup(input int t, input int per, input int pre, input logic route);
    bus(1'b1, 1'b1, slot(t, OFS_PERIOD_LO), 32'(per));
    bus(1'b1, 1'b0, slot(t, OFS_PRESCALE), 32'(pre));
    bus(1'b1, 1'b0, slot(t, OFS_CTRL), 32'h3 | (32'(route) << CTRL_ROUTE13_BIT));
  endtask
  task automatic final_report;
    $display("checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    frame = '0;
    arst_n = 1'b0;
    ack_en = 1'b0;
    ack_dly = 4'h0;
    cyc = 0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(58));
    repeat (10) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    for (int t = 0; t < 3; t++) begin
      rd_chk(1'b1, slot(t, OFS_PERIOD_LO), 32'hffff_ffff);
      rd_chk(1'b0, slot(t, OFS_PRESCALE), 32'h0000_0001);
    end
    rd_chk(1'b1, 6'h20, 32'h0);
    bus(1'b1, 1'b0, slot(0, OFS_PERIOD_LO), 32'h0000_5a5a);
    bus(1'b1, 1'b0, slot(0, OFS_PERIOD_HI), 32'h0000_00c3);
    rd_chk(1'b1, slot(0, OFS_PERIOD_LO), 32'h00c3_5a5a);
    rd_chk(1'b0, slot(0, OFS_PERIOD_HI), 32'h0000_00c3);
    // Stopping freezes the count, so a wide read of it must match the port.
    bus(1'b1, 1'b0, slot(0, OFS_CTRL), 32'(1) << CTRL_STOP_BIT);
    held = count[0];
    repeat (10) @(posedge core_clk);
    #1;
    check(count[0], held, "stopped count moved");
    rd_chk(1'b1, slot(0, OFS_COUNT_LO), held);
    bus(1'b1, 1'b0, slot(0, OFS_CTRL), 32'h0);
    check(32'(count[0] != held), 32'h1, "count did not resume");
    // Without its route bit timer 1 may flag internally but must keep line 13 low.
    setup(1, 5, 1, 1'b0);
    repeat (20) @(posedge core_clk);
    #1;
    check(32'(irq[1]), 32'h0, "line 13 unrouted");
    rd_chk(1'b0, slot(1, OFS_CTRL), 32'(1) << CTRL_FLAG_BIT);
    ack_en = 1'b1;
    // The first passes visit every timer and the divide-by-one and by-three corners.
    for (int j = 0; j < 8; j++) begin
      k = (j < 3) ? j : $urandom_range(0, 2);
      p = $urandom_range(5, 40);
      ps = (j == 0) ? 0 : (j == 1) ? 3 : $urandom_range(0, 4);
      ack_dly = 4'($urandom_range(0, 2));
      setup(k, p, ps, k == LINE13_TIMER);
      wait_rise(k, t0);
      check(count[k], 32'(p), "count after wrap");
      wait_rise(k, t1);
      check(32'(t1 - t0), 32'(gap(p, ps)), "spacing");
    end
    // A long period keeps the next wrap away from the clear below.
    ack_en = 1'b0;
    setup(2, 200, 1, 1'b0);
    wait_rise(2, t0);
    repeat (30) @(posedge core_clk);
    #1;
    check(32'(irq[2]), 32'h1, "flag sticky");
    bus(1'b1, 1'b0, slot(2, OFS_CTRL), 32'(1) << CTRL_CLEAR_BIT);
    check(32'(irq[2]), 32'h0, "flag cleared");
    final_report();
  end
  initial begin
    #(20 * 60000);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
